// File: core/wwdt_device.sv
/*
  Window watchdog device: control and window registers, fuse load,
  write synchronisation into the tick domain and the timeout sequencer.
  Assumes the controller drives the link from flops on the same clock and
  that the fuse inputs are static while the clock runs.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module wwdt_device #(
  parameter int TICK_DIV = wwdt_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  wwdt_if.dev link,
  input wire logic lock_fuse,
  input wire logic [wwdt_pkg::SEL_W-1:0] timeout_default_fuse,
  input wire logic [wwdt_pkg::SEL_W-1:0] closed_window_default_fuse,
  input wire logic enable_default_fuse,
  input wire logic window_default_fuse,
  output logic system_reset_req
);
  import wwdt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // 1 kHz tick from the system clock

  logic [14:0] div_cnt;
  logic tick;
  wire div_wrap = (div_cnt == 15'(TICK_DIV - 1));

  // the tick times the closed and open windows; the reset state counts system clock cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 15'h0000;
      tick <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 15'h0000 : div_cnt + 15'h0001;
      tick <= div_wrap;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software-visible register copies

  logic loaded;
  logic [3:0] sh_sel;
  logic sh_en;
  logic sh_ctrl_unlock;
  logic [3:0] sh_csel;
  logic sh_win;
  logic sh_win_unlock;

  // write acceptance: protection window open and change bit in the same write
  wire wr_base = link.reg_wr && link.protect_open;
  wire wr_ctrl_ok = wr_base && (link.reg_sel == IDX_CTRL)
                    && link.reg_wdata[UNLOCK_BIT] && !lock_fuse;
  wire wr_win_ok = wr_base && (link.reg_sel == IDX_WINDOW)
                   && link.reg_wdata[UNLOCK_BIT];
  wire wr_any = wr_ctrl_ok || wr_win_ok;
  wire [3:0] wr_sel = link.reg_wdata[SEL_LSB +: SEL_W];
  wire wr_mode = link.reg_wdata[MODE_BIT];

  // reset can only load constants, so the fuses are taken one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loaded <= 1'b0;
      sh_sel <= SEL_RESET;
      sh_en <= 1'b0;
      sh_ctrl_unlock <= UNLOCK_RESET;
      sh_csel <= SEL_RESET;
      sh_win <= 1'b0;
      sh_win_unlock <= UNLOCK_RESET;
    end else if (!loaded) begin
      loaded <= 1'b1;
      sh_sel <= timeout_default_fuse;
      sh_en <= enable_default_fuse;
      sh_csel <= closed_window_default_fuse;
      sh_win <= window_default_fuse;
    end else begin
      if (wr_ctrl_ok) begin
        sh_sel <= wr_sel;
        sh_en <= wr_mode;
        sh_ctrl_unlock <= 1'b1;
      end
      if (wr_win_ok) begin
        sh_win <= wr_mode;
        sh_win_unlock <= 1'b1;
        // the lock fuse leaves the mode bit writable but not the period
        if (!lock_fuse) begin
          sh_csel <= wr_sel;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settings seen by the sequencer, updated on a tick

  logic [3:0] act_sel;
  logic act_en;
  logic [3:0] act_csel;
  logic act_win;
  logic busy;
  wire sync_ok = busy && tick && (act_en || sh_en);

  // a new write in the tick cycle keeps busy set, so no value is skipped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_sel <= SEL_RESET;
      act_en <= 1'b0;
      act_csel <= SEL_RESET;
      act_win <= 1'b0;
      busy <= 1'b0;
    end else if (!loaded) begin
      act_sel <= timeout_default_fuse;
      act_en <= enable_default_fuse;
      act_csel <= closed_window_default_fuse;
      act_win <= window_default_fuse;
    end else if (wr_any) begin
      busy <= 1'b1;
    end else if (sync_ok) begin
      busy <= 1'b0;
      act_sel <= sh_sel;
      act_en <= sh_en;
      act_csel <= sh_csel;
      act_win <= sh_win;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // restart request stage

  logic kick_q;

  // one register stage; the controller's pulse is one cycle, so seen once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= link.kick;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // timeout sequencer

  wwdt_state_t state;
  wwdt_state_t next_state;
  logic [13:0] count;
  logic [13:0] next_count;
  logic [4:0] rst_cnt;
  logic [4:0] next_rst_cnt;
  wire [13:0] count_inc = count + 14'h0001;
  wire [13:0] closed_len = wwdt_period(act_csel);
  wire [13:0] open_len = wwdt_period(act_sel);
  wire rst_done = (rst_cnt == 5'(RST_CYCLES - 1));

  // no sleep input exists: counting never pauses while enabled
  always_comb begin
    next_state = state;
    next_count = count;
    next_rst_cnt = rst_cnt;
    case (state)
      ST_IDLE: begin
        next_count = 14'h0000;
        if (act_en) begin
          next_state = act_win ? ST_CLOSED : ST_OPEN;
        end
      end
      ST_CLOSED: begin
        if (!act_en) begin
          next_state = ST_IDLE;
        end else if (kick_q) begin
          next_state = ST_RESET;
          next_rst_cnt = 5'h00;
        end else if (tick) begin
          if (count_inc >= closed_len) begin
            next_state = ST_OPEN;
            next_count = 14'h0000;
          end else begin
            next_count = count_inc;
          end
        end
      end
      ST_OPEN: begin
        if (!act_en) begin
          next_state = ST_IDLE;
        end else if (kick_q) begin
          // a restart beats an expiry landing in the same cycle
          next_state = act_win ? ST_CLOSED : ST_OPEN;
          next_count = 14'h0000;
        end else if (tick) begin
          if (count_inc >= open_len) begin
            next_state = ST_RESET;
            next_rst_cnt = 5'h00;
          end else begin
            next_count = count_inc;
          end
        end
      end
      ST_RESET: begin
        next_rst_cnt = rst_cnt + 5'h01;
        if (rst_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_count = 14'h0000;
        next_rst_cnt = 5'h00;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      count <= 14'h0000;
      rst_cnt <= 5'h00;
    end else begin
      state <= next_state;
      count <= next_count;
      rst_cnt <= next_rst_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  // reset pulse aligned with the reset state, RST_CYCLES long
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_req <= 1'b0;
      link.wdt_reset <= 1'b0;
      link.rd_ctrl <= 8'h00;
      link.rd_window <= 8'h00;
      link.rd_status <= 8'h00;
    end else begin
      system_reset_req <= (next_state == ST_RESET);
      link.wdt_reset <= (next_state == ST_RESET);
      link.rd_ctrl <= {2'h0, sh_sel, sh_en, sh_ctrl_unlock};
      link.rd_window <= {2'h0, sh_csel, sh_win, sh_win_unlock};
      link.rd_status <= {7'h00, busy};
    end
  end

endmodule

// File: core/wwdt_host.sv
/*
  Controller end: an AXI4-Lite slave whose registers issue restarts,
  open the timed protection window and forward writes to the device.
  Assumes a well-behaved AXI4-Lite master on the same clock.
*/
`timescale 1ns/10ps
module wwdt_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [wwdt_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [wwdt_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  wwdt_if.host link
);
  import wwdt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // write channel capture

  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  wire do_write = aw_got && w_got && !bvalid;
  wire hit_cmd = (aw_addr == OFS_CMD);
  wire hit_dev = (aw_addr == OFS_DEVWR);
  wire wr_bad = !(hit_cmd || hit_dev);

  // address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_data <= wdata;
        w_lane0 <= wstrb[0];
        wready <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link drive: restart pulse, protection window, device write

  logic [4:0] prot_cnt;
  wire cmd_ok = do_write && hit_cmd && w_lane0;
  wire open_req = cmd_ok && w_data[CMD_PROTECT_BIT];
  wire [4:0] next_prot_cnt = open_req ? 5'(PROTECT_CYCLES)
                           : (prot_cnt != 5'h00) ? prot_cnt - 5'h01 : 5'h00;

  // software must open the window shortly before each device write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_cnt <= 5'h00;
      link.protect_open <= 1'b0;
      link.kick <= 1'b0;
      link.reg_wr <= 1'b0;
      link.reg_sel <= IDX_CTRL;
      link.reg_wdata <= 8'h00;
    end else begin
      prot_cnt <= next_prot_cnt;
      link.protect_open <= (next_prot_cnt != 5'h00);
      link.kick <= cmd_ok && w_data[CMD_KICK_BIT];
      link.reg_wr <= do_write && hit_dev && w_lane0;
      if (do_write && hit_dev) begin
        link.reg_sel <= w_data[DEVWR_SEL_BIT];
        link.reg_wdata <= w_data[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel

  wire rd_ok = (araddr == OFS_CMD) || (araddr == OFS_DEVWR) || (araddr == OFS_CTRLRD)
               || (araddr == OFS_WINRD) || (araddr == OFS_STAT);
  wire [31:0] rd_mux = (araddr == OFS_CMD) ? {30'h0, link.protect_open, 1'b0}
                     : (araddr == OFS_DEVWR) ? {23'h0, link.reg_sel, link.reg_wdata}
                     : (araddr == OFS_CTRLRD) ? {24'h0, link.rd_ctrl}
                     : (araddr == OFS_WINRD) ? {24'h0, link.rd_window}
                     : (araddr == OFS_STAT) ? {29'h0, link.wdt_reset, link.protect_open,
                                               link.rd_status[0]}
                     : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

// File: core/wwdt_if.sv
/*
  Link between the watchdog device and its controller.
  Assumes both ends share the system clock; every signal is driven by a flop.
*/
`timescale 1ns/10ps
interface wwdt_if;
  logic reg_wr;
  logic reg_sel;
  logic [7:0] reg_wdata;
  logic kick;
  logic protect_open;
  logic [7:0] rd_ctrl;
  logic [7:0] rd_window;
  logic [7:0] rd_status;
  logic wdt_reset;

  modport dev (
    input reg_wr, reg_sel, reg_wdata, kick, protect_open,
    output rd_ctrl, rd_window, rd_status, wdt_reset
  );
  modport host (
    output reg_wr, reg_sel, reg_wdata, kick, protect_open,
    input rd_ctrl, rd_window, rd_status, wdt_reset
  );
endinterface

// File: core/wwdt_pkg.sv
/*
  Shared constants, types and helpers for the window watchdog and its
  bus-side controller.
  Assumes a single 20 MHz system clock; the 1 kHz watchdog rate is a tick
  derived from it.
*/
package wwdt_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 50;
  localparam int TICK_HZ = 1000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  // one cycle of the 2 MHz oscillator, the shortest legal reset pulse
  localparam int RST_PULSE_NS = 500;
  localparam int RST_CYCLES = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROTECT_CYCLES = 16;

  ////////////////////////////////////////////////////////////////////////
  // device register indices and field layout
  localparam logic IDX_CTRL = 1'h0;
  localparam logic IDX_WINDOW = 1'h1;
  localparam int UNLOCK_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam int SEL_LSB = 2;
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_MAX = 4'ha;
  localparam logic [13:0] BASE_PERIOD = 14'h0008;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic UNLOCK_RESET = 1'h0;

  ////////////////////////////////////////////////////////////////////////
  // controller register map (byte addresses)
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DEVWR = 8'h04;
  localparam logic [7:0] OFS_CTRLRD = 8'h08;
  localparam logic [7:0] OFS_WINRD = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int CMD_KICK_BIT = 0;
  localparam int CMD_PROTECT_BIT = 1;
  localparam int DEVWR_SEL_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // watchdog sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CLOSED = 4'h2,
    ST_OPEN = 4'h4,
    ST_RESET = 4'h8
  } wwdt_state_t;

  // ticks for a select code; reserved codes fall back to the longest period
  function automatic logic [13:0] wwdt_period(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > SEL_MAX) ? SEL_MAX : sel;
    return BASE_PERIOD << s;
  endfunction

endpackage

// File: test/tb.sv
/*
  Bench for the watchdog pair: drives the controller over AXI4-Lite and
  checks the device through read-back registers and its reset output.
  Assumes the package constants and a shortened tick divider.
*/
`timescale 1ns/10ps
module tb;
  import wwdt_pkg::*;
  localparam int TD = 4;
  localparam int LIMIT = 90000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic lock = 1'b0, en_f = 1'b0, win_f = 1'b0, rst_q = 1'b0;
  logic [3:0] to_f = 4'h3;
  logic awready, wready, bvalid, arready, rvalid, sys_rst;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int fails = 0, n_compared = 0, cyc = 0, n_rst = 0, n, k;

  ////////////////////////////////////////////////////////////////////////////////
  wwdt_if wwdt_if_i ();
  wwdt_device #(.TICK_DIV(TD)) wwdt_device_i (.aclk(aclk), .aresetn(aresetn),
    .link(wwdt_if_i), .lock_fuse(lock), .timeout_default_fuse(to_f),
    .closed_window_default_fuse(4'h5), .enable_default_fuse(en_f),
    .window_default_fuse(win_f), .system_reset_req(sys_rst));
  wwdt_host wwdt_host_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(wwdt_if_i));
  wwdt_properties wwdt_properties_i (.aclk(aclk), .aresetn(aresetn),
    .reg_wr(wwdt_if_i.reg_wr), .reg_sel(wwdt_if_i.reg_sel),
    .reg_wdata(wwdt_if_i.reg_wdata), .kick(wwdt_if_i.kick),
    .protect_open(wwdt_if_i.protect_open), .rd_ctrl(wwdt_if_i.rd_ctrl),
    .rd_window(wwdt_if_i.rd_window), .rd_status(wwdt_if_i.rd_status),
    .wdt_reset(wwdt_if_i.wdt_reset));

  // clock, cycle count, reset-pulse count and hang guard
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    rst_q <= sys_rst;
    if (sys_rst && !rst_q) n_rst <= n_rst + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict in one place, reached by the main sequence or the hang guard
  task automatic summarize;
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // durations and counts measured by the bench itself
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // fuses only change while reset is held, since the device samples them live
  task automatic do_reset(input logic lk, input logic en, input logic [3:0] to,
                          input logic wn);
    @(posedge aclk);
    aresetn <= 1'b0;
    lock <= lk;
    en_f <= en;
    to_f <= to;
    win_f <= wn;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    rs = rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, d, r);
    chk(d, exp);
  endtask

  task automatic cmd(input logic [31:0] v);
    axi_wr(OFS_CMD, v, r);
  endtask

  // protected device write; the upper two bits always go out as zero
  task automatic pdev(input logic sel, input logic [7:0] v);
    cmd(32'h2);
    axi_wr(OFS_DEVWR, {23'h0, sel, 2'h0, v[5:0]}, r);
  endtask

  task automatic wait_rise(output int cnt);
    int t0;
    t0 = cyc;
    while (!sys_rst) @(posedge aclk);
    cnt = cyc - t0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    do_reset(1'b0, 1'b0, 4'h3, 1'b0);
    rdc(OFS_CTRLRD, 32'h0c);
    rdc(OFS_WINRD, 32'h14);
    axi_rd(8'h14, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(OFS_CTRLRD, 32'h0, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(OFS_DEVWR, 32'h03, r);
    rdc(OFS_CTRLRD, 32'h0c);
    pdev(1'b0, 8'h02);
    rdc(OFS_CTRLRD, 32'h0c);
    pdev(1'b1, 8'h15);
    pdev(1'b1, 8'h02);
    rdc(OFS_DEVWR, 32'h102);
    repeat (20) @(posedge aclk);
    axi_rd(OFS_STAT, d, r);
    chk(d, 32'h1);
    rdc(OFS_WINRD, 32'h15);
    pdev(1'b0, 8'h03);
    rdc(OFS_CTRLRD, 32'h03);
    // busy needs a tick plus a cycle to clear; the window is still open
    repeat (4) @(posedge aclk);
    axi_rd(OFS_STAT, d, r);
    chk(d, 32'h2);
    // restarts faster than the period keep the reset away
    k = n_rst;
    repeat (6) begin
      cmd(32'h1);
      repeat (8) @(posedge aclk);
    end
    chk_rng(n_rst - k, 0, 0);
    pdev(1'b0, 8'h01);
    k = n_rst;
    repeat (200) @(posedge aclk);
    chk_rng(n_rst - k, 0, 0);
    // every documented select code, timed from a restart
    for (int c = 0; c <= 10; c++) begin
      pdev(1'b0, {2'h0, c[3:0], 2'h3});
      cmd(32'h1);
      wait_rise(n);
      chk_rng(n, ((8 << c) - 1) * TD, (8 << c) * TD + 12);
      while (sys_rst) @(posedge aclk);
    end
    // window mode: closed and open both eight ticks
    pdev(1'b0, 8'h03);
    pdev(1'b1, 8'h03);
    wait_rise(n);
    while (sys_rst) @(posedge aclk);
    repeat (40) @(posedge aclk);
    k = n_rst;
    cmd(32'h1);
    // long enough for the unkicked expiry, still inside the new closed window
    repeat (22) @(posedge aclk);
    chk_rng(n_rst - k, 0, 0);
    cmd(32'h1);
    wait_rise(n);
    chk_rng(n, 0, 4);
    axi_rd(OFS_STAT, d, r);
    chk(d, 32'h4);
    while (sys_rst) @(posedge aclk);
    wait_rise(n);
    chk_rng(n, 15 * TD, 16 * TD + 12);
    // lock fuse freezes control and closed select, not the mode bit
    do_reset(1'b1, 1'b1, 4'ha, 1'b1);
    rdc(OFS_CTRLRD, 32'h2a);
    rdc(OFS_WINRD, 32'h16);
    pdev(1'b0, 8'h01);
    rdc(OFS_CTRLRD, 32'h2a);
    pdev(1'b1, 8'h01);
    rdc(OFS_WINRD, 32'h15);
    summarize();
  end
endmodule

// File: test/wwdt_properties.sv
/*
  Concurrent checks on the link between the watchdog device and its controller.
  Assumes it sits beside the link instance, on the same clock and reset.
*/
`timescale 1ns/10ps
module wwdt_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reg_wr,
  input wire logic reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic kick,
  input wire logic protect_open,
  input wire logic [7:0] rd_ctrl,
  input wire logic [7:0] rd_window,
  input wire logic [7:0] rd_status,
  input wire logic wdt_reset
);
  // one clock domain, so clock and disable are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // reset pulse is ten cycles, the floor of one slow-oscillator period
  property p_reset_pulse;
    $rose(wdt_reset) |-> wdt_reset [*8] ##1 wdt_reset ##1 wdt_reset ##1 !wdt_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse length wrong");

  // a write without its change-unlock bit leaves the register alone
  property p_ctrl_no_unlock;
    reg_wr && !reg_sel && !reg_wdata[0] |-> ##2 rd_ctrl == $past(rd_ctrl, 2);
  endproperty
  a_ctrl_no_unlock: assert property (p_ctrl_no_unlock) else $error("ctrl changed");

  property p_win_no_unlock;
    reg_wr && reg_sel && !reg_wdata[0] |-> ##2 rd_window == $past(rd_window, 2);
  endproperty
  a_win_no_unlock: assert property (p_win_no_unlock) else $error("window changed");

  // outside the timed window nothing moves
  property p_unprotected;
    reg_wr && !protect_open |-> ##2 rd_ctrl == $past(rd_ctrl, 2) &&
      rd_window == $past(rd_window, 2);
  endproperty
  a_unprotected: assert property (p_unprotected) else $error("unprotected write took");

  // the mode bit stays writable even under the lock fuse
  property p_win_mode_write;
    reg_wr && reg_sel && reg_wdata[0] && protect_open |->
      ##2 rd_window[1:0] == {$past(reg_wdata[1], 2), 1'b1};
  endproperty
  a_win_mode_write: assert property (p_win_mode_write) else $error("mode bit not taken");

  property p_reserved_zero;
    rd_ctrl[7:6] == 2'h0 && rd_window[7:6] == 2'h0 && rd_status[7:1] == 7'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  ////////////////////////////////////////////////////////////////////////////////
  // busy shows for an accepted window write and clears within a few ticks when enabled
  property p_busy_set;
    reg_wr && reg_sel && reg_wdata[0] && protect_open |-> ##2 rd_status[0];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");

  property p_busy_clear;
    $rose(rd_status[0]) && rd_ctrl[1] |-> ##[1:40] !rd_status[0];
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");

  // a restart in normal mode cannot be followed at once by a reset
  property p_kick_holds;
    kick && !wdt_reset && !rd_window[1] && rd_ctrl[1] |=> !wdt_reset [*8];
  endproperty
  a_kick_holds: assert property (p_kick_holds) else $error("reset after restart");
endmodule
